// file: rtl/fpm_cfg.svh
// Purpose: constants of the four-level FSK packet modem datapath
// Assumes: host strobes and link inputs are synchronous to clk
// Notes: offsets are register select codes, not byte addresses
`ifndef FPM_CFG_SVH
`define FPM_CFG_SVH
`define FPM_SEL_BUF 2'h0
`define FPM_SEL_CMD 2'h1
`define FPM_SEL_CTRL 2'h2
`define FPM_SEL_MODE 2'h3
`define FPM_CMD_TASK_LSB 0
`define FPM_CMD_IMP 4
`define FPM_CMD_CRC 5
`define FPM_CTRL_EYE 0
`define FPM_CTRL_EXTREF 1
`define FPM_MODE_TX 0
`define FPM_REG_RESET 8'h00
`define FPM_BUF_BYTES 12
`define FPM_RAW_SYMS 48
`define FPM_FMT_SYMS 64
`define FPM_SYNC_SYMS 24
`define FPM_SYNC_PATTERN 48'hA5F0C3_3C0F5A
`define FPM_CRC_POLY 8'h07
`define FPM_SETTLE_SYMS 4'h8
`define FPM_CLK_HZ 125000000
`define FPM_SYM_RATE 4800
`define FPM_SYM_CYCLES (`FPM_CLK_HZ / `FPM_SYM_RATE)
`endif

// file: rtl/fpm_datapath.sv
// Purpose: host port, payload buffer, block coding and symbol timing of the modem
// Assumes: rxCode is the sliced two-bit symbol; extRefTick is a one-cycle pulse
// Notes: correction code is one parity bit per three data bits, so it detects, not repairs
`include "fpm_cfg.svh"
module fpm_datapath #(
	parameter int SymDiv = `FPM_SYM_CYCLES
) (
	// Clock and reset
	input wire logic clk,
	input wire logic resetn,
	// Host port
	input wire fpm_pkg::fpm_host_type host,
	output logic [7:0] dataOut,
	output logic dataOe,
	// Link
	input wire logic [1:0] rxCode,
	input wire logic extRefTick,
	output fpm_pkg::fpm_tx_type txOut,
	output logic rxEqualise
);
	import fpm_pkg::*;

	logic [7:0] cmd, ctrl, mode, quality, next_cmd, next_ctrl, next_mode, next_quality;
	logic [7:0] buffer [`FPM_BUF_BYTES];
	logic [7:0] next_buffer [`FPM_BUF_BYTES];
	logic [3:0] ptr, next_ptr, settle, next_settle;
	logic [5:0] idx, next_idx;
	logic [15:0] phase, next_phase;
	logic [127:0] txVec, next_txVec, rxVec, next_rxVec;
	logic [47:0] syncReg, next_syncReg;
	logic [1:0] rxPrev;
	logic wrPrev, rdPrev, fmt, next_fmt, crcErr, next_crcErr, found, next_found;
	fpm_state_type state, next_state;
	logic [7:0] next_dataOut;
	logic next_dataOe, next_rxEqualise;
	fpm_tx_type next_txOut;

	logic [95:0] flat, flatCrc, decFmt, decRaw;
	logic [127:0] rawVec, codedVec;
	logic [31:0] errFlag;
	logic [7:0] errCount, status;
	logic modeTx, busy, wrEdge, rdEdge, tick, rxTick, lastSym, crcOn;
	logic [1:0] sel;
	logic [5:0] slot;

	function automatic logic [7:0] crc8(input logic [95:0] v);
		logic [7:0] c;
		logic fb;
		c = 8'h00;
		for (int i = 0; i < 88; i++) begin
			fb = c[7] ^ v[8 * (i / 8) + 7 - (i % 8)];
			c = {c[6:0], 1'b0};
			if (fb) begin
				c = c ^ `FPM_CRC_POLY;
			end
		end
		return c;
	endfunction

	// Byte b of the payload sits in flat[8b+7:8b]
	for (genvar b = 0; b < `FPM_BUF_BYTES; b++) begin : g_flat
		assign flat[8 * b +: 8] = buffer[b];
	end
	assign crcOn = (wrEdge && sel == `FPM_SEL_CMD) ? host.dataIn[`FPM_CMD_CRC] : cmd[`FPM_CMD_CRC];
	assign flatCrc = crcOn ? {crc8(flat), flat[87:0]} : flat;
	// Four symbols per byte, high pair first
	for (genvar n = 0; n < `FPM_RAW_SYMS; n++) begin : g_raw
		assign rawVec[2 * n +: 2] = flatCrc[8 * (n / 4) + 6 - 2 * (n % 4) +: 2];
		assign decRaw[8 * (n / 4) + 6 - 2 * (n % 4) +: 2] = rxVec[2 * n +: 2];
	end
	assign rawVec[127:96] = 32'h0000_0000;
	// Three data bits plus parity form two symbols
	for (genvar g = 0; g < 32; g++) begin : g_fec
		assign codedVec[4 * g +: 4] = {flatCrc[3 * g +: 3], ^flatCrc[3 * g +: 3]};
		assign decFmt[3 * g +: 3] = rxVec[4 * g + 1 +: 3];
		assign errFlag[g] = ^rxVec[4 * g +: 4];
	end

	always_comb begin
		errCount = 8'h00;
		for (int g = 0; g < 32; g++) begin
			errCount = errCount + {7'h00, errFlag[g]};
		end
	end

	assign modeTx = mode[`FPM_MODE_TX];
	assign busy = state != ST_IDLE;
	assign sel = {host.reg_select_hi, host.reg_select_lo};
	assign wrEdge = !wrPrev && host.write_strobe_n && !host.chip_select_n;
	assign rdEdge = !rdPrev && host.read_strobe_n && !host.chip_select_n;
	assign status = {3'h0, busy, modeTx, found, crcErr, !busy};
	// Interleave is an 8x8 transpose of the 64 coded symbols
	assign slot = fmt ? {idx[2:0], idx[5:3]} : idx;
	assign rxTick = phase == 16'h0000;
	assign tick = ctrl[`FPM_CTRL_EXTREF] ? extRefTick : rxTick;
	assign lastSym = idx == (fmt ? 6'(`FPM_FMT_SYMS - 1) : 6'(`FPM_RAW_SYMS - 1));

	always_comb begin
		next_cmd = cmd;
		next_ctrl = ctrl;
		next_mode = mode;
		next_quality = quality;
		next_buffer = buffer;
		next_ptr = ptr;
		next_settle = settle;
		next_idx = idx;
		next_txVec = txVec;
		next_rxVec = rxVec;
		next_syncReg = syncReg;
		next_fmt = fmt;
		next_crcErr = crcErr;
		next_found = found;
		next_state = state;
		next_phase = rxTick ? 16'(SymDiv - 1) : phase - 16'h0001;
		// Re-centre the phase on every received level change in receive mode
		if (!modeTx && rxCode != rxPrev) begin
			next_phase = 16'(SymDiv / 2);
		end
		if (settle != 4'h0 && tick) begin
			next_settle = settle - 4'h1;
		end
		if (wrEdge) begin
			unique case (sel)
				`FPM_SEL_BUF: begin
					// Buffer frozen while a task owns it
					if (!busy) begin
						next_buffer[ptr] = host.dataIn;
					end
					next_ptr = (ptr == 4'(`FPM_BUF_BYTES - 1)) ? 4'h0 : ptr + 4'h1;
				end
				`FPM_SEL_CMD: begin
					next_cmd = host.dataIn;
					next_ptr = 4'h0;
					next_idx = 6'h00;
					next_state = ST_IDLE;
					unique case (host.dataIn[`FPM_CMD_TASK_LSB +: 3])
						TASK_TX_FMT, TASK_TX_RAW: if (modeTx) begin
							next_fmt = host.dataIn[2:0] == TASK_TX_FMT;
							next_state = ST_TX;
						end
						TASK_RX_FMT, TASK_RX_RAW: if (!modeTx) begin
							next_fmt = host.dataIn[2:0] == TASK_RX_FMT;
							next_state = ST_RX;
						end
						TASK_SEARCH: if (!modeTx) begin
							next_found = 1'b0;
							next_state = ST_SEARCH;
						end
						default: next_state = ST_IDLE;
					endcase
				end
				`FPM_SEL_CTRL: next_ctrl = host.dataIn;
				`FPM_SEL_MODE: begin
					next_mode = host.dataIn;
					if (!modeTx && host.dataIn[`FPM_MODE_TX]) begin
						next_settle = `FPM_SETTLE_SYMS;
					end
				end
			endcase
		end
		if (rdEdge && sel == `FPM_SEL_BUF) begin
			next_ptr = (ptr == 4'(`FPM_BUF_BYTES - 1)) ? 4'h0 : ptr + 4'h1;
		end
		unique case (state)
			ST_IDLE: next_txVec = next_fmt ? codedVec : rawVec;
			ST_TX: if (tick && settle == 4'h0) begin
				next_idx = idx + 6'h01;
				if (lastSym) begin
					next_state = ST_IDLE;
				end
			end
			ST_RX: if (rxTick) begin
				next_rxVec[2 * slot +: 2] = rxCode;
				next_idx = idx + 6'h01;
				if (lastSym) begin
					next_state = ST_DECODE;
				end
			end
			ST_DECODE: begin
				for (int b = 0; b < `FPM_BUF_BYTES; b++) begin
					next_buffer[b] = fmt ? decFmt[8 * b +: 8] : decRaw[8 * b +: 8];
				end
				next_crcErr = fmt && cmd[`FPM_CMD_CRC] && crc8(decFmt) != decFmt[95:88];
				next_quality = fmt ? errCount : quality;
				next_state = ST_IDLE;
			end
			ST_SEARCH: if (rxTick && !modeTx) begin
				next_syncReg = {syncReg[45:0], rxCode};
				if ({syncReg[45:0], rxCode} == `FPM_SYNC_PATTERN) begin
					next_found = 1'b1;
					next_state = ST_IDLE;
				end
			end
		endcase
		// Host side read mux; unused fourth address reads zero
		unique case (sel)
			`FPM_SEL_BUF: next_dataOut = buffer[ptr];
			`FPM_SEL_CMD: next_dataOut = status;
			`FPM_SEL_CTRL: next_dataOut = quality;
			`FPM_SEL_MODE: next_dataOut = 8'h00;
		endcase
		next_dataOe = !host.chip_select_n && !host.read_strobe_n;
		next_rxEqualise = cmd[`FPM_CMD_IMP];
		next_txOut.code = txVec[2 * slot +: 2];
		// Impulse shaping keeps the level one cycle per symbol
		next_txOut.active = state == ST_TX && settle == 4'h0 && (!cmd[`FPM_CMD_IMP] || tick);
		if (modeTx) begin
			next_txOut.drive = (state == ST_TX && settle == 4'h0) ? DRV_FILTER : DRV_BIAS;
		end else begin
			next_txOut.drive = ctrl[`FPM_CTRL_EYE] ? DRV_RX : DRV_BIAS;
		end
	end

	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			cmd <= `FPM_REG_RESET;
			ctrl <= `FPM_REG_RESET;
			mode <= `FPM_REG_RESET;
			quality <= `FPM_REG_RESET;
			for (int b = 0; b < `FPM_BUF_BYTES; b++) begin
				buffer[b] <= 8'h00;
			end
			ptr <= 4'h0;
			settle <= 4'h0;
			idx <= 6'h00;
			phase <= 16'h0000;
			txVec <= 128'h0;
			rxVec <= 128'h0;
			syncReg <= 48'h0;
			rxPrev <= 2'h0;
			wrPrev <= 1'b1;
			rdPrev <= 1'b1;
			fmt <= 1'b0;
			crcErr <= 1'b0;
			found <= 1'b0;
			state <= ST_IDLE;
			dataOut <= 8'h00;
			dataOe <= 1'b0;
			rxEqualise <= 1'b0;
			txOut <= '{code: 2'h0, active: 1'b0, drive: DRV_BIAS};
		end else begin
			cmd <= next_cmd;
			ctrl <= next_ctrl;
			mode <= next_mode;
			quality <= next_quality;
			buffer <= next_buffer;
			ptr <= next_ptr;
			settle <= next_settle;
			idx <= next_idx;
			phase <= next_phase;
			txVec <= next_txVec;
			rxVec <= next_rxVec;
			syncReg <= next_syncReg;
			rxPrev <= rxCode;
			wrPrev <= host.write_strobe_n;
			rdPrev <= host.read_strobe_n;
			fmt <= next_fmt;
			crcErr <= next_crcErr;
			found <= next_found;
			state <= next_state;
			dataOut <= next_dataOut;
			dataOe <= next_dataOe;
			rxEqualise <= next_rxEqualise;
			txOut <= next_txOut;
		end
	end
	property p_cmd_write;
		@(posedge clk) disable iff (!resetn) wrEdge && sel == `FPM_SEL_CMD |=> cmd == $past(host.dataIn);
	endproperty
	a_cmd_write: assert property (p_cmd_write) else $error("command write lost");
	property p_read_drive;
		@(posedge clk) disable iff (!resetn) dataOe |-> $past(!host.chip_select_n && !host.read_strobe_n);
	endproperty
	a_read_drive: assert property (p_read_drive) else $error("bus driven outside read");
	property p_ptr_step;
		@(posedge clk) disable iff (!resetn)
			rdEdge && sel == `FPM_SEL_BUF && ptr < 4'hB |=> ptr == $past(ptr) + 4'h1;
	endproperty
	a_ptr_step: assert property (p_ptr_step) else $error("buffer pointer did not step");
	property p_settle;
		@(posedge clk) disable iff (!resetn) settle != 4'h0 && modeTx |=> txOut.drive == DRV_BIAS;
	endproperty
	a_settle: assert property (p_settle) else $error("output left bias while settling");
	property p_sync_rx;
		@(posedge clk) disable iff (!resetn) $rose(found) |-> !$past(modeTx);
	endproperty
	a_sync_rx: assert property (p_sync_rx) else $error("frame sync found in transmit");
	property p_eye;
		@(posedge clk) disable iff (!resetn) !modeTx ##1 !modeTx |-> txOut.drive == ($past(ctrl[0]) ? DRV_RX : DRV_BIAS);
	endproperty
	a_eye: assert property (p_eye) else $error("receive output source wrong");
	property p_unused_read;
		@(posedge clk) disable iff (!resetn) sel == `FPM_SEL_MODE ##1 dataOe |-> dataOut == 8'h00;
	endproperty
	a_unused_read: assert property (p_unused_read) else $error("unused address read nonzero");
	property p_equalise;
		@(posedge clk) disable iff (!resetn) wrEdge && sel == `FPM_SEL_CMD |-> ##2 rxEqualise == $past(host.dataIn[4], 2);
	endproperty
	a_equalise: assert property (p_equalise) else $error("equaliser select mismatch");
endmodule

// file: rtl/fpm_pkg.sv
// Purpose: shared types of the modem datapath
// Assumes: nothing beyond the constants header
// Notes: task codes are the low three command bits
package fpm_pkg;
	typedef enum logic [2:0] {
		TASK_IDLE = 3'h0,
		TASK_TX_FMT = 3'h1,
		TASK_RX_FMT = 3'h2,
		TASK_TX_RAW = 3'h3,
		TASK_RX_RAW = 3'h4,
		TASK_SEARCH = 3'h5
	} fpm_task_type;
	typedef enum logic [1:0] {DRV_BIAS, DRV_FILTER, DRV_RX} fpm_drive_type;
	typedef enum logic [2:0] {ST_IDLE, ST_TX, ST_RX, ST_DECODE, ST_SEARCH} fpm_state_type;
	typedef struct packed {
		logic chip_select_n;
		logic write_strobe_n;
		logic read_strobe_n;
		logic reg_select_hi;
		logic reg_select_lo;
		logic [7:0] dataIn;
	} fpm_host_type;
	typedef struct packed {
		logic [1:0] code;
		logic active;
		fpm_drive_type drive;
	} fpm_tx_type;
endpackage

// file: test/fpm_host_model.sv
// Purpose: host processor model on the modem register port
// Assumes: strobes are launched just after rising edges of clk
// Notes: idle data lines carry the inverse of the last byte, never a frozen value
module fpm_host_model (
	// Clock
	input wire logic clk,
	// Register port
	output fpm_pkg::fpm_host_type host,
	input wire logic [7:0] dataOut,
	input wire logic dataOe
);
	timeunit 1ns;
	timeprecision 1ps;
	import fpm_pkg::*;
	initial host = '{1'b1, 1'b1, 1'b1, 1'b0, 1'b0, 8'hFF};
	task automatic wr(input logic [1:0] sel, input logic [7:0] d);
		@(posedge clk);
		host.chip_select_n <= 1'b0;
		host.write_strobe_n <= 1'b0;
		{host.reg_select_hi, host.reg_select_lo} <= sel;
		host.dataIn <= d;
		@(posedge clk);
		host.write_strobe_n <= 1'b1;
		@(posedge clk);
		host.chip_select_n <= 1'b1;
		host.dataIn <= ~d;
	endtask
	task automatic rd(input logic [1:0] sel, output logic [7:0] d, output logic oe);
		@(posedge clk);
		host.chip_select_n <= 1'b0;
		host.read_strobe_n <= 1'b0;
		{host.reg_select_hi, host.reg_select_lo} <= sel;
		repeat (2) @(posedge clk);
		d = dataOut;
		oe = dataOe;
		host.read_strobe_n <= 1'b1;
		@(posedge clk);
		host.chip_select_n <= 1'b1;
	endtask
	// Polling costs bus cycles but keeps buffer traffic away from a running task
	task automatic waitFree();
		logic [7:0] s;
		logic oe;
		s = 8'h00;
		for (int n = 0; n < 500 && s[0] !== 1'b1; n++) begin
			rd(2'h1, s, oe);
		end
	endtask
endmodule

// file: test/tb_top.sv
// Purpose: self-checking bench of the modem datapath
// Assumes: symbol divider shortened to 8 clocks
// Notes: formatted coding is checked by loopback, so a slip made alike on both sides goes unseen
`include "fpm_cfg.svh"
`define CHK(nm, e, g) check(nm, 48'(e), 48'(g))
module tb_top;
	timeunit 1ns;
	timeprecision 1ps;
	import fpm_pkg::*;
	localparam int Div = 8;
	logic clk = 1'b0;
	logic resetn = 1'b0;
	fpm_host_type host;
	logic [7:0] dataOut;
	logic dataOe;
	logic [1:0] rxCode = 2'h0;
	logic extRefTick = 1'b0;
	fpm_tx_type txOut;
	logic rxEqualise;
	int miscompares = 0;
	int checksDone = 0;
	int cycles = 0;
	logic [7:0] pay [12];
	logic [1:0] syms [64];
	logic [7:0] b;
	logic oe;
	fpm_datapath #(.SymDiv(Div)) fpm_datapath_inst (.clk(clk), .resetn(resetn), .host(host), .dataOut(dataOut),
		.dataOe(dataOe), .rxCode(rxCode), .extRefTick(extRefTick), .txOut(txOut), .rxEqualise(rxEqualise));
	fpm_host_model fpm_host_model_inst (.clk(clk), .host(host), .dataOut(dataOut), .dataOe(dataOe));
	always #4 clk = ~clk;
	// External reference faster than the divider, so the source choice shows in symbol spacing
	always @(posedge clk) begin
		cycles <= cycles + 1;
		extRefTick <= (cycles % 6 == 0);
		if (cycles == 30000) begin
			miscompares++;
			wrap_up();
		end
	end
	task automatic check(input string nm, input logic [47:0] e, input logic [47:0] g);
		checksDone++;
		if (g !== e) begin
			miscompares++;
			$display("[FAIL] %s expected %0h seen %0h", nm, e, g);
		end
	endtask
	task automatic wrap_up();
		$display("checks %0d mismatches %0d", checksDone, miscompares);
		if (miscompares == 0 && checksDone > 0) begin
			$display("RESULT: PASS");
		end else begin
			$display("RESULT: FAIL");
		end
		$finish;
	endtask
	task automatic w(input logic [1:0] s, input logic [7:0] d);
		fpm_host_model_inst.wr(s, d);
	endtask
	task automatic r(input logic [1:0] s);
		fpm_host_model_inst.rd(s, b, oe);
	endtask
	task automatic send(input int n);
		for (int i = 0; i < n; i++) begin
			@(posedge clk);
			rxCode <= syms[i];
			repeat (Div - 1) @(posedge clk);
		end
		@(posedge clk);
		rxCode <= ~syms[n - 1];
	endtask
	// Line idles on the inverse of the first symbol so the first change recentres sampling
	task automatic rx(input int n, input logic [7:0] cmd);
		rxCode <= ~syms[0];
		repeat (Div) @(posedge clk);
		fork
			send(n);
			w(2'h1, cmd);
		join
		fpm_host_model_inst.waitFree();
	endtask
	task automatic grab(input int n, input int gap);
		int k;
		k = 0;
		for (int t = 0; t < 2000 && k < n; t++) begin
			@(posedge clk);
			if (txOut.active === 1'b1) begin
				if (k == 0) `CHK("tx drive", DRV_FILTER, txOut.drive);
				syms[k] = txOut.code;
				k++;
				if (gap > 0) repeat (gap - 1) @(posedge clk);
			end
		end
		`CHK("symbol count", n, k);
	endtask
	task automatic load();
		fpm_host_model_inst.waitFree();
		w(2'h1, 8'h00);
		for (int i = 0; i < 12; i++) begin
			pay[i] = 8'($urandom);
			w(2'h0, pay[i]);
		end
	endtask
	initial begin
		void'($urandom(59709));
		repeat (5) @(posedge clk);
		`CHK("reset drive", DRV_BIAS, txOut.drive);
		`CHK("reset read enable", 1'b0, dataOe);
		@(posedge clk);
		resetn <= 1'b1;
		r(2'h1);
		`CHK("idle free", 1'b1, b[0]);
		`CHK("read enable", 1'b1, oe);
		r(2'h3);
		`CHK("unused read", 8'h00, b);
		@(posedge clk);
		`CHK("read release", 1'b0, dataOe);
		for (int e = 0; e < 2; e++) begin
			w(2'h2, 8'(1 - e));
			repeat (3) @(posedge clk);
			`CHK("eye source", e ? DRV_BIAS : DRV_RX, txOut.drive);
		end
		$display("test registers done");
		for (int i = 0; i < 48; i++) syms[i] = 2'($urandom);
		rx(48, 8'h04);
		for (int i = 0; i < 12; i++) begin
			r(2'h0);
			`CHK("rx raw byte", {syms[4 * i], syms[4 * i + 1], syms[4 * i + 2], syms[4 * i + 3]}, b);
		end
		`CHK("rx no equalise", 1'b0, rxEqualise);
		$display("test raw receive done");
		for (int i = 0; i < 24; i++) syms[i] = 2'(`FPM_SYNC_PATTERN >> (46 - 2 * i));
		rx(24, 8'h05);
		r(2'h1);
		`CHK("frame found", 1'b1, b[2]);
		$display("test frame search done");
		w(2'h3, 8'h01);
		// Start a send at once so the settle window holds back a running task
		w(2'h1, 8'h03);
		repeat (20) @(posedge clk);
		`CHK("settle bias", DRV_BIAS, txOut.drive);
		`CHK("settle quiet", 1'b0, txOut.active);
		r(2'h1);
		`CHK("status busy tx", 2'h3, b[4:3]);
		for (int p = 0; p < 2; p++) begin
			w(2'h2, 8'(2 * p));
			load();
			w(2'h1, 8'h03);
			grab(48, p ? 6 : Div);
			for (int i = 0; i < 48; i++) `CHK("tx raw sym", pay[i / 4][7 - 2 * (i % 4) -: 2], syms[i]);
		end
		$display("test raw transmit done");
		w(2'h2, 8'h00);
		load();
		w(2'h1, 8'h31);
		grab(64, 0);
		w(2'h3, 8'h00);
		for (int p = 0; p < 2; p++) begin
			syms[9] = syms[9] ^ 2'(p);
			rx(64, 8'h32);
			`CHK("rx equalise", 1'b1, rxEqualise);
			r(2'h2);
			`CHK("quality", p, b);
			// The flipped symbol lands on bit 5 of byte 1, so the checksum must see it
			r(2'h1);
			`CHK("crc flag", p, b[1]);
			for (int i = 0; i < 11; i++) begin
				r(2'h0);
				`CHK("loop byte", pay[i] ^ ((p == 1 && i == 1) ? 8'h20 : 8'h00), b);
			end
		end
		$display("test loopback done");
		wrap_up();
	end
endmodule
